// ### verilog/mode_select_consts.vh
// Constants for the drive operation mode selector.
`ifndef MODE_SELECT_CONSTS_VH
`define MODE_SELECT_CONSTS_VH
// Register byte addresses.
`define ADDR_MODE_SETTING   4'h0
`define ADDR_CONTROL        4'h4
`define ADDR_STATUS         4'h8
`define ADDR_WRITE_POLICY   4'hC
// Mode setting codes.
`define MS_SWITCH_EXT_PU    3'h0
`define MS_FIXED_PU         3'h1
`define MS_FIXED_EXT        3'h2
`define MS_COMBINED_1       3'h3
`define MS_COMBINED_2       3'h4
`define MS_SWITCHOVER       3'h6
`define MS_INTERLOCK        3'h7
`define MS_RESET_VALUE      3'h0
`define MS_UNUSED_CODE      3'h5
// Active operation mode codes.
`define OP_TERMINAL         2'h0
`define OP_KEYPAD           2'h1
`define OP_REMOTE           2'h2
`define OP_COMBINED         2'h3
// Frequency source codes.
`define FS_PANEL            3'h0
`define FS_TERM2            3'h1
`define FS_TERM4            3'h2
`define FS_MULTI            3'h3
`define FS_LOOP             3'h4
`define FS_JOG              3'h5
`define FS_REMOTE           3'h6
// Control register bit positions.
`define CTL_REQ_VALID       0
`define CTL_REQ_LO          1
`define CTL_REQ_HI          2
`define CTL_PARAM_WR        3
`define CTL_STOP_ALL_N      4
`endif

// ### verilog/mode_fsm.v
// Operation mode state register with switch acceptance logic.
`timescale 1ns/1ps
`include "mode_select_consts.vh"
module mode_fsm (
  // Clock and reset.
  input  wire       clock,
  input  wire       resetn,
  // Mode setting and requests.
  input  wire [2:0] mode_setting,
  input  wire       setting_written,
  input  wire       switch_req,
  input  wire [1:0] switch_target,
  input  wire       panel_lockout_input,
  // Current mode.
  output reg  [1:0] op_mode_reg
);
  reg        switch_ok;
  reg  [1:0] op_mode_next;
  // Power-on mode for each setting.
  function [1:0] entry_mode;
    input [2:0] s;
    begin
      case (s)
        `MS_FIXED_PU:   entry_mode = `OP_KEYPAD;
        `MS_COMBINED_1: entry_mode = `OP_COMBINED;
        `MS_COMBINED_2: entry_mode = `OP_COMBINED;
        default:        entry_mode = `OP_TERMINAL;
      endcase
    end
  endfunction
  // Decide acceptance of a switch and the next mode.
  always @* begin
    case (mode_setting)
      `MS_SWITCH_EXT_PU: switch_ok = (switch_target == `OP_TERMINAL) ||
                                     (switch_target == `OP_KEYPAD); // RL3
      `MS_SWITCHOVER:    switch_ok = (switch_target != `OP_COMBINED); // RL16
      `MS_INTERLOCK:     switch_ok = panel_lockout_input &&
                                     (switch_target != `OP_COMBINED); // RL12
      default:           switch_ok = 1'b0; // RL2 RL4 RL5 RL8
    endcase
    op_mode_next = op_mode_reg;
    if (setting_written) begin
      op_mode_next = entry_mode(mode_setting);
    end else if ((mode_setting == `MS_INTERLOCK) && !panel_lockout_input) begin
      op_mode_next = `OP_TERMINAL; // RL17
    end else if (switch_req && switch_ok) begin
      op_mode_next = switch_target; // RL19
    end
  end
  // Mode register, reloaded to the reset setting's entry mode.
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      op_mode_reg <= `OP_TERMINAL; // RL1 RL19
    end else begin
      op_mode_reg <= op_mode_next;
    end
  end
endmodule // mode_fsm

// ### verilog/freq_source_mux.v
// Selects the frequency source for the active mode.
`timescale 1ns/1ps
`include "mode_select_consts.vh"
module freq_source_mux (
  // Mode inputs.
  input  wire [1:0] op_mode,
  input  wire [2:0] mode_setting,
  // Frequency qualifiers.
  input  wire       multi_speed_active,
  input  wire       loop_control_enable,
  input  wire       analog_current_select,
  input  wire       jog_input,
  // Selected source.
  output reg  [2:0] freq_source
);
  // Priority selection per mode.
  always @* begin
    freq_source = `FS_PANEL;
    if (op_mode == `OP_REMOTE) begin
      freq_source = `FS_REMOTE; // RL13
    end else if (op_mode == `OP_KEYPAD) begin
      freq_source = `FS_PANEL;
    end else if ((op_mode == `OP_COMBINED) && (mode_setting == `MS_COMBINED_1)) begin
      if (multi_speed_active) begin
        freq_source = `FS_MULTI; // RL6
      end else if (loop_control_enable) begin
        freq_source = `FS_LOOP; // RL6
      end else if (analog_current_select) begin
        freq_source = `FS_TERM4; // RL6 RL7
      end else begin
        freq_source = `FS_PANEL; // RL6
      end
    end else begin
      if (jog_input) begin
        freq_source = `FS_JOG; // RL8 RL9
      end else if (multi_speed_active) begin
        freq_source = `FS_MULTI; // RL9
      end else if (analog_current_select) begin
        freq_source = `FS_TERM4; // RL9
      end else begin
        freq_source = `FS_TERM2; // RL9
      end
    end
  end
endmodule // freq_source_mux

// ### verilog/drive_operation_mode_select.v
// Operation mode selector of a motor drive with an Avalon-MM register port.
//
// Function
// RL1: Codes 0 and 2 start in terminal mode.
// RL2: Code 2 locks terminal mode.
// RL3: Code 0 toggles terminal and keypad modes.
// RL4: Code 1 fixes keypad mode.
// RL5: Code 3: panel frequency, terminal start.
// RL6: Code 3 frequency priority: multi, loop, term4, panel.
// RL7: Combined mode uses terminal 4 when selected.
// RL8: Code 4: terminal frequency, keypad start.
// RL9: Terminal mode uses start inputs and terminals.
// RL10: Terminal mode refuses ordinary parameter writes.
// RL11: Mode setting writable in every mode.
// RL12: Code 7 switching only with lockout on.
// RL13: Remote mode takes commands from link.
// RL14: Mode change from panel or link.
// RL15: Keypad stop honoured in every mode.
// RL16: Code 6 switches modes while running.
// RL17: Code 7 forces terminal when lockout off.
// RL18: Invalid mode codes are rejected.
// RL19: Mode held in register, changed on accept.
`timescale 1ns/1ps
`include "mode_select_consts.vh"
module drive_operation_mode_select (
  // Clock and reset.
  input  wire        clock,
  input  wire        resetn,
  // Avalon-MM slave.
  input  wire [3:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  output reg  [31:0] readdata,
  output wire        waitrequest,
  // Operator keypad.
  input  wire        keypad_toggle_key,
  input  wire        keypad_run_key,
  input  wire        keypad_fwd_key,
  input  wire        keypad_rev_key,
  input  wire        keypad_stop_key,
  input  wire [15:0] panel_freq,
  // Remote link.
  input  wire        link_mode_req,
  input  wire [1:0]  link_mode_target,
  input  wire        link_run_fwd,
  input  wire        link_run_rev,
  input  wire [15:0] link_freq,
  // Control terminals.
  input  wire        forward_start_input,
  input  wire        reverse_start_input,
  input  wire [3:0]  multi_speed_inputs,
  input  wire        loop_control_enable,
  input  wire        analog_current_select,
  input  wire        panel_lockout_input,
  input  wire        jog_input,
  input  wire [15:0] term2_freq,
  input  wire [15:0] term4_freq,
  input  wire [15:0] multi_speed_freq,
  input  wire [15:0] loop_freq,
  input  wire [15:0] jog_freq,
  // Drive command outputs.
  output reg         run_forward,
  output reg         run_reverse,
  output reg  [15:0] freq_command,
  output reg  [2:0]  freq_source_sel,
  output wire [1:0]  op_mode,
  output reg         param_write_ok
);
  // Width of the multi-speed input field.
  localparam MULTI_W = 4;
  // Stored settings written over the bus.
  reg  [2:0]  mode_setting_reg;
  reg  [1:0]  param_write_policy_reg;
  reg         stop_all_modes_reg;
  // Bus handshake state and one-cycle strobes towards the mode register.
  reg         setting_written_reg;
  reg         reg_req_reg;
  reg  [1:0]  reg_target_reg;
  reg         ack_reg;
  reg         reject_reg;
  // Keypad edge detection and the merged switch request.
  reg         toggle_prev_reg;
  reg         switch_req;
  reg  [1:0]  switch_target;
  // Next values of the registered drive commands.
  reg         run_fwd_next;
  reg         run_rev_next;
  reg  [15:0] freq_next;
  // Combinational helpers.
  wire [2:0]  freq_source;
  wire        toggle_edge;
  wire        bus_access;
  wire        write_done;
  wire        stop_active;
  wire        multi_speed_active;
  wire [4:0]  multi_chain;
  genvar      gi;

  // Legal setting codes; the one unused code is refused and not stored.
  function legal_code;
    input [2:0] c;
    begin
      legal_code = (c != `MS_UNUSED_CODE); // RL18
    end
  endfunction

  // True while the keypad owns the start and frequency commands.
  function is_keypad;
    input [1:0] m;
    begin
      is_keypad = (m == `OP_KEYPAD);
    end
  endfunction

  // Keypad forward start: the panel run key or the keypad forward key.
  function keypad_forward;
    input run_key;
    input fwd_key;
    begin
      keypad_forward = run_key || fwd_key;
    end
  endfunction

  // One wait state per access: a request is taken while ack_reg is low and
  // completes in the next cycle with waitrequest low. ack_reg also blocks a
  // second take of a request that the master still holds at completion.
  assign bus_access  = (read || write) && !ack_reg;
  assign waitrequest = (read || write) && !ack_reg;
  assign write_done  = write && ack_reg;
  assign toggle_edge = keypad_toggle_key && !toggle_prev_reg;

  // Multi-speed is active while any of its inputs is high, an OR chain
  // built one stage per input bit.
  assign multi_chain[0] = 1'b0;
  generate
    for (gi = 0; gi < MULTI_W; gi = gi + 1) begin : g_multi_or
      assign multi_chain[gi+1] = multi_chain[gi] | multi_speed_inputs[gi];
    end
  endgenerate
  assign multi_speed_active = multi_chain[MULTI_W];

  // Bus register writes and read data capture.
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      // Stop key acts in every mode after reset; the setting restarts at code 0.
      ack_reg                <= 1'b0;
      readdata               <= 32'h0000_0000;
      mode_setting_reg       <= `MS_RESET_VALUE;
      param_write_policy_reg <= 2'h0;
      stop_all_modes_reg     <= 1'b1;
      setting_written_reg    <= 1'b0;
      reg_req_reg            <= 1'b0;
      reg_target_reg         <= `OP_TERMINAL;
      reject_reg             <= 1'b0;
    end else begin
      ack_reg             <= bus_access;
      setting_written_reg <= 1'b0;
      reg_req_reg         <= 1'b0;
      // Writes commit at the edge that completes the transfer, when the
      // master sees waitrequest low, so a write never lands while stalled.
      if (write_done) begin
        case (address)
          `ADDR_MODE_SETTING: begin
            // Always writable, independent of write policy and mode.
            if (legal_code(writedata[2:0])) begin // RL11 RL18
              mode_setting_reg    <= writedata[2:0];
              setting_written_reg <= 1'b1;
              reject_reg          <= 1'b0;
            end else begin
              reject_reg <= 1'b1; // RL18
            end
          end
          `ADDR_CONTROL: begin
            // A switch request lasts one cycle; the stop selection is stored.
            reg_req_reg        <= writedata[`CTL_REQ_VALID]; // RL14
            reg_target_reg     <= writedata[`CTL_REQ_HI:`CTL_REQ_LO];
            stop_all_modes_reg <= !writedata[`CTL_STOP_ALL_N];
          end
          `ADDR_WRITE_POLICY: param_write_policy_reg <= writedata[1:0];
          default: ;
        endcase
      end
      // Read data is captured in the wait cycle and stands at the completing edge.
      if (bus_access && read) begin
        case (address)
          `ADDR_MODE_SETTING: readdata <= {29'h0, mode_setting_reg};
          `ADDR_CONTROL:      readdata <= {27'h0, !stop_all_modes_reg, 4'h0};
          // Status shows the live mode and source, not a stored copy.
          `ADDR_STATUS:       readdata <= {25'h0, reject_reg, param_write_ok,
                                           freq_source, op_mode};
          `ADDR_WRITE_POLICY: readdata <= {30'h0, param_write_policy_reg};
          default:            readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Gather switch requests: link first, then register, then keypad toggle.
  // One request reaches the mode register per cycle; lower ones are dropped.
  always @* begin
    switch_req    = 1'b0;
    switch_target = `OP_TERMINAL;
    if (link_mode_req) begin
      switch_req    = 1'b1; // RL14
      switch_target = link_mode_target;
    end else if (reg_req_reg) begin
      switch_req    = 1'b1; // RL14
      switch_target = reg_target_reg;
    end else if (toggle_edge) begin
      switch_req    = 1'b1; // RL3
      switch_target = is_keypad(op_mode) ? `OP_TERMINAL : `OP_KEYPAD;
    end
  end

  // Mode state register and switch acceptance.
  mode_fsm u_mode_fsm (
    .clock               (clock),
    .resetn              (resetn),
    .mode_setting        (mode_setting_reg),
    .setting_written     (setting_written_reg),
    .switch_req          (switch_req),
    .switch_target       (switch_target),
    .panel_lockout_input (panel_lockout_input),
    .op_mode_reg         (op_mode)
  );

  // Frequency source priority for the active mode.
  freq_source_mux u_freq_source_mux (
    .op_mode               (op_mode),
    .mode_setting          (mode_setting_reg),
    .multi_speed_active    (multi_speed_active),
    .loop_control_enable   (loop_control_enable),
    .analog_current_select (analog_current_select),
    .jog_input             (jog_input),
    .freq_source           (freq_source)
  );

  // Keypad stop acts in every mode unless disabled, always in keypad mode.
  // The stop key is a level, so a held key keeps both directions off.
  assign stop_active = keypad_stop_key && (stop_all_modes_reg || is_keypad(op_mode)); // RL15

  // Start command and frequency selection.
  always @* begin
    case (op_mode)
      // Keypad mode: the panel run key or the keypad keys start the motor.
      `OP_KEYPAD: begin
        run_fwd_next = keypad_forward(keypad_run_key, keypad_fwd_key);
        run_rev_next = keypad_rev_key;
      end
      // Remote mode: both directions come from the serial link.
      `OP_REMOTE: begin
        run_fwd_next = link_run_fwd; // RL13
        run_rev_next = link_run_rev; // RL13
      end
      // Combined modes: code 3 starts from the terminals, code 4 from the keypad.
      `OP_COMBINED: begin
        if (mode_setting_reg == `MS_COMBINED_1) begin
          run_fwd_next = forward_start_input; // RL5
          run_rev_next = reverse_start_input; // RL5
        end else begin
          run_fwd_next = keypad_forward(keypad_run_key, keypad_fwd_key); // RL8
          run_rev_next = keypad_rev_key; // RL8
        end
      end
      // Terminal mode: the start terminals drive the motor.
      default: begin
        run_fwd_next = forward_start_input; // RL9
        run_rev_next = reverse_start_input; // RL9
      end
    endcase
    // Frequency value of the selected source.
    case (freq_source)
      `FS_TERM2:  freq_next = term2_freq;
      `FS_TERM4:  freq_next = term4_freq; // RL7
      `FS_MULTI:  freq_next = multi_speed_freq;
      `FS_LOOP:   freq_next = loop_freq;
      `FS_JOG:    freq_next = jog_freq;
      `FS_REMOTE: freq_next = link_freq;
      default:    freq_next = panel_freq;
    endcase
  end

  // Registered command outputs: every command follows its inputs one cycle
  // later, and opposing directions or an active stop key hold both off.
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      run_forward     <= 1'b0;
      run_reverse     <= 1'b0;
      freq_command    <= 16'h0000;
      freq_source_sel <= `FS_PANEL;
      param_write_ok  <= 1'b0;
      toggle_prev_reg <= 1'b0;
    end else begin
      // Key history for the toggle edge; reset low, the key's idle level.
      toggle_prev_reg <= keypad_toggle_key;
      run_forward     <= run_fwd_next && !run_rev_next && !stop_active;
      run_reverse     <= run_rev_next && !run_fwd_next && !stop_active;
      freq_command    <= freq_next;
      freq_source_sel <= freq_source;
      param_write_ok  <= (op_mode != `OP_TERMINAL); // RL10
    end
  end
endmodule // drive_operation_mode_select

// ### tb/drive_operation_mode_select_assertions.sv
// Port checks for the operation mode selector.
`timescale 1ns/1ps
`include "mode_select_consts.vh"
module mode_select_checker (
  // Clock, reset and bus strobes.
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic        read,
  input wire logic        write,
  input wire logic        waitrequest,
  // Command inputs.
  input wire logic        keypad_stop_key,
  input wire logic        forward_start_input,
  input wire logic        reverse_start_input,
  input wire logic        link_run_fwd,
  input wire logic        link_run_rev,
  input wire logic [15:0] link_freq,
  // Drive outputs.
  input wire logic        run_forward,
  input wire logic        run_reverse,
  input wire logic [15:0] freq_command,
  input wire logic [2:0]  freq_source_sel,
  input wire logic [1:0]  op_mode,
  input wire logic        param_write_ok
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // Steps of a stalled request, a start request and a held mode.
  sequence s_req;
    (read || write) && waitrequest;
  endsequence
  sequence s_fwd;
    forward_start_input && !reverse_start_input && !keypad_stop_key && op_mode == `OP_TERMINAL;
  endsequence
  sequence s_lfwd;
    link_run_fwd && !link_run_rev && !keypad_stop_key && op_mode == `OP_REMOTE;
  endsequence
  sequence s_term;
    op_mode == `OP_TERMINAL ##1 op_mode == `OP_TERMINAL;
  endsequence
  sequence s_remote;
    op_mode == `OP_REMOTE ##1 op_mode == `OP_REMOTE;
  endsequence
  a_bus_stall: assert property ($rose(read || write) |-> waitrequest)
    else $error("request not stalled");
  a_bus_answer: assert property (s_req |=> !waitrequest)
    else $error("no answer after one wait");
  a_stop_all: assert property (keypad_stop_key |=> !run_forward && !run_reverse)
    else $error("stop key ignored");
  a_run_single: assert property (!(run_forward && run_reverse))
    else $error("both directions on");
  a_term_start: assert property (s_fwd ##1 op_mode == `OP_TERMINAL |-> run_forward)
    else $error("terminal start ignored");
  a_remote_run: assert property (s_lfwd ##1 op_mode == `OP_REMOTE |-> run_forward)
    else $error("link start ignored");
  a_remote_freq: assert property (s_remote |-> freq_command == $past(link_freq))
    else $error("link frequency not used");
  a_param_block: assert property (s_term |-> !param_write_ok)
    else $error("writes allowed in terminal mode");
endmodule // mode_select_checker

bind drive_operation_mode_select mode_select_checker u_checker (.*);

// ### tb/drive_partner_model.sv
// Far-side model: serial link master and analog source values.
`timescale 1ns/1ps
module drive_partner_model (
  // Clock and bench commands.
  input  wire logic       clock,
  input  wire logic       link_go,
  input  wire logic [1:0] link_tgt,
  // Link and source outputs.
  output logic            link_mode_req,
  output logic [1:0]      link_mode_target,
  output logic [15:0]     link_freq,
  output logic [15:0]     term2_freq,
  output logic [15:0]     term4_freq,
  output logic [15:0]     multi_speed_freq,
  output logic [15:0]     loop_freq,
  output logic [15:0]     jog_freq
);
  logic go_q = 1'h0;
  // Distinct source values so each selection shows at the output.
  assign link_freq = 16'h7777;
  assign term2_freq = 16'h1111;
  assign term4_freq = 16'h2222;
  assign multi_speed_freq = 16'h3333;
  assign loop_freq = 16'h4444;
  assign jog_freq = 16'h5555;
  // A rising bench command becomes a one-cycle mode change instruction.
  always @(posedge clock) begin
    go_q <= link_go;
    link_mode_req <= link_go && !go_q;
    link_mode_target <= link_tgt;
  end
endmodule // drive_partner_model

// ### tb/drive_operation_mode_select_tb_top.sv
// Self-checking bench for the operation mode selector.
`timescale 1ns/1ps
`include "mode_select_consts.vh"
module drive_operation_mode_select_tb_top;
  logic        clock, resetn, read, write, waitrequest, link_go, link_mode_req;
  logic        keypad_toggle_key, keypad_run_key, keypad_fwd_key, keypad_rev_key;
  logic        keypad_stop_key, link_run_fwd, link_run_rev, forward_start_input;
  logic        reverse_start_input, loop_control_enable, analog_current_select;
  logic        panel_lockout_input, jog_input, run_forward, run_reverse, param_write_ok;
  logic [1:0]  link_tgt, link_mode_target, op_mode;
  logic [2:0]  freq_source_sel;
  logic [3:0]  address, multi_speed_inputs;
  logic [15:0] panel_freq, link_freq, term2_freq, term4_freq, multi_speed_freq;
  logic [15:0] loop_freq, jog_freq, freq_command;
  logic [31:0] writedata, readdata, q;
  int          n_fail, num_checks;

  drive_operation_mode_select DUT (.*);
  drive_partner_model u_partner (.*);

  // Free-running system clock.
  initial begin
    clock = 1'h0;
    forever #25 clock = ~clock;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t %s: got %0h exp %0h", $time, m, got, exp);
    end
  endtask

  task finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // One bus cycle: the request is held until waitrequest is sampled low at a
  // rising edge, where read data is taken and the request is released.
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int i;
    @(posedge clock);
    address <= a;
    write <= w;
    read <= !w;
    writedata <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge clock);
      if (waitrequest === 1'h0) break;
    end
    q = readdata;
    write <= 1'h0;
    read <= 1'h0;
    if (i == 20) begin
      chk(32'h0, 32'h1, "bus timeout");
      finish_test;
    end
  endtask

  task settle;
    repeat (4) @(posedge clock);
    @(negedge clock);
  endtask

  task mode_is(input logic [1:0] m);
    settle;
    chk(op_mode, m, "mode");
  endtask

  task src(input logic [2:0] s, input logic [15:0] f);
    settle;
    chk(freq_source_sel, s, "source");
    chk(freq_command, f, "frequency");
  endtask

  task toggle;
    @(posedge clock) keypad_toggle_key <= 1'h1;
    @(posedge clock) keypad_toggle_key <= 1'h0;
  endtask

  task link(input logic [1:0] t);
    @(posedge clock) link_tgt <= t;
    link_go <= 1'h1;
    @(posedge clock) link_go <= 1'h0;
  endtask

  task t_power_on;
    mode_is(`OP_TERMINAL);
    chk(param_write_ok, 1'h0, "param lock");
    bus(1'h0, `ADDR_MODE_SETTING, 32'h0);
    chk(q[2:0], `MS_RESET_VALUE, "setting");
    bus(1'h0, 4'h2, 32'h0);
    chk(q, 32'h0, "unmapped");
    @(posedge clock) forward_start_input <= 1'h1;
    src(`FS_TERM2, 16'h1111);
    chk(run_forward, 1'h1, "ext run");
    @(posedge clock) keypad_stop_key <= 1'h1;
    settle;
    chk(run_forward, 1'h0, "stop key");
    @(posedge clock) keypad_stop_key <= 1'h0;
    $display("test power_on done");
  endtask

  task t_fixed;
    bus(1'h1, `ADDR_MODE_SETTING, 32'h2);
    toggle;
    link(`OP_KEYPAD);
    mode_is(`OP_TERMINAL);
    bus(1'h1, `ADDR_MODE_SETTING, 32'h0);
    mode_is(`OP_TERMINAL);
    toggle;
    mode_is(`OP_KEYPAD);
    chk(param_write_ok, 1'h1, "param open");
    bus(1'h1, `ADDR_WRITE_POLICY, 32'h1);
    bus(1'h1, `ADDR_MODE_SETTING, 32'h1);
    mode_is(`OP_KEYPAD);
    toggle;
    link(`OP_TERMINAL);
    mode_is(`OP_KEYPAD);
    bus(1'h0, `ADDR_MODE_SETTING, 32'h0);
    chk(q[2:0], 3'h1, "setting");
    bus(1'h0, `ADDR_WRITE_POLICY, 32'h0);
    chk(q[1:0], 2'h1, "policy");
    $display("test fixed done");
  endtask

  task t_comb1;
    logic [2:0]  ss [4] = '{`FS_MULTI, `FS_LOOP, `FS_TERM4, `FS_PANEL};
    logic [15:0] fs [4] = '{16'h3333, 16'h4444, 16'h2222, 16'h0100};
    int          i;
    bus(1'h1, `ADDR_MODE_SETTING, 32'h3);
    link(`OP_REMOTE);
    mode_is(`OP_COMBINED);
    for (i = 0; i < 4; i++) begin
      @(posedge clock) multi_speed_inputs <= {3'h0, i < 1};
      loop_control_enable <= i < 2;
      analog_current_select <= i < 3;
      src(ss[i], fs[i]);
    end
    chk(run_forward, 1'h1, "ext start");
    $display("test comb1 done");
  endtask

  task t_comb2;
    bus(1'h1, `ADDR_MODE_SETTING, 32'h4);
    @(posedge clock) jog_input <= 1'h1;
    keypad_rev_key <= 1'h1;
    forward_start_input <= 1'h0;
    src(`FS_JOG, 16'h5555);
    chk(run_reverse, 1'h1, "key start");
    @(posedge clock) jog_input <= 1'h0;
    keypad_rev_key <= 1'h0;
    toggle;
    mode_is(`OP_COMBINED);
    bus(1'h1, `ADDR_MODE_SETTING, 32'h5);
    bus(1'h0, `ADDR_STATUS, 32'h0);
    chk(q[6], 1'h1, "reject flag");
    bus(1'h0, `ADDR_MODE_SETTING, 32'h0);
    chk(q[2:0], 3'h4, "setting kept");
    $display("test comb2 done");
  endtask

  task t_switch;
    bus(1'h1, `ADDR_MODE_SETTING, 32'h6);
    link(`OP_REMOTE);
    mode_is(`OP_REMOTE);
    @(posedge clock) link_run_fwd <= 1'h1;
    src(`FS_REMOTE, 16'h7777);
    chk(run_forward, 1'h1, "link start");
    @(posedge clock) link_run_fwd <= 1'h0;
    bus(1'h1, `ADDR_CONTROL, {29'h0, `OP_KEYPAD, 1'h1});
    mode_is(`OP_KEYPAD);
    bus(1'h1, `ADDR_CONTROL, 32'h0);
    bus(1'h0, `ADDR_STATUS, 32'h0);
    chk(q[1:0], `OP_KEYPAD, "status");
    $display("test switch done");
  endtask

  task t_interlock;
    @(posedge clock) panel_lockout_input <= 1'h1;
    bus(1'h1, `ADDR_MODE_SETTING, 32'h7);
    mode_is(`OP_TERMINAL);
    link(`OP_KEYPAD);
    mode_is(`OP_KEYPAD);
    @(posedge clock) panel_lockout_input <= 1'h0;
    mode_is(`OP_TERMINAL);
    link(`OP_REMOTE);
    mode_is(`OP_TERMINAL);
    $display("test interlock done");
  endtask

  // Reset, then every scenario in turn.
  initial begin
    n_fail = 0;
    num_checks = 0;
    {resetn, read, write, link_go, link_tgt, address, writedata} = '0;
    {keypad_toggle_key, keypad_run_key, keypad_fwd_key, keypad_rev_key, keypad_stop_key} = '0;
    {link_run_fwd, link_run_rev, forward_start_input, reverse_start_input, jog_input} = '0;
    {multi_speed_inputs, loop_control_enable, analog_current_select, panel_lockout_input} = '0;
    panel_freq = 16'h0100;
    repeat (8) @(posedge clock);
    resetn <= 1'h1;
    t_power_on;
    t_fixed;
    t_comb1;
    t_comb2;
    t_switch;
    t_interlock;
    finish_test;
  end
endmodule // drive_operation_mode_select_tb_top
